// File: sim/dms_core_model.sv
// core-side model: instruction boundaries, interrupt entry and return
// assumes the bench raises irq_pend as a level and drops it once taken
`timescale 1ns/1ps
module dms_core_model
   import dms_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic irq_pend,
   input  wire logic irq_taken_reg,
   output logic      irq_req,
   output logic      instr_done,
   output logic      irq_return
);
   int cnt;
   int dep;
   int tmr;
   // pending source is already individually enabled
   assign irq_req = irq_pend;
   // boundary every fourth cycle; each service routine runs a fixed time
   always @(negedge mclk) begin
      cnt        <= rst ? 0 : cnt + 1;
      instr_done <= !rst && (cnt % 4 == 3);
      irq_return <= 1'h0;
      if (rst) begin
         dep <= 0;
         tmr <= 0;
      end else if (irq_taken_reg) begin
         dep <= dep + 1;
         tmr <= 40;
      end else if (tmr > 0) begin
         tmr <= tmr - 1;
      end else if (dep > 0 && cnt % 4 == 3) begin
         irq_return <= 1'h1; // nested routines unwind one per pulse
         dep        <= dep - 1;
         tmr        <= 40;
      end
   end
endmodule : dms_core_model

// File: sim/dms_data_mem_tb.sv
// self-checking bench for the data memory block against a queue-free model
// assumes dms_core_model supplies instruction boundaries and returns
`timescale 1ns/1ps
module dms_data_mem_tb
   import dms_pkg::*;
;
   logic        mclk = 1'h0;
   logic        rst = 1'h1;
   logic        irq_pend, acc_valid, acc_write, acc_indirect, acc_bit, acc_ptr_sel, acc_wbit;
   logic        stk_push, stk_pop, stk_call, rd_valid_reg, rd_bit_reg, irq_taken_reg;
   logic        paged_req_reg, paged_we_reg;
   logic [7:0]  acc_addr, acc_wdata, stk_wdata, irq_page, rd_data_reg, stack_pointer_reg;
   logic [7:0]  program_status_word_reg, interrupt_enable_reg, active_page_reg;
   logic [7:0]  paged_addr_reg, paged_page_reg, paged_wdata_reg, d, b;
   logic [31:0] stack_record_reg, port_latch_reg, rec;
   logic [7:0]  mem [256];
   logic [7:0]  special_function_register [256];
   logic [1:0]  bank;
   wire         irq_req, instr_done, irq_return;
   int          error_cnt = 0;
   int          check_count = 0;
   int          cyc = 0;

   dms_core_model core (.mclk, .rst, .irq_pend, .irq_taken_reg, .irq_req, .instr_done, .irq_return);
   dms_data_mem dut (.mclk, .rst, .acc_valid, .acc_write, .acc_indirect, .acc_bit, .acc_ptr_sel,
      .acc_addr, .acc_wdata, .acc_wbit, .stk_push, .stk_pop, .stk_call, .stk_wdata, .irq_req,
      .irq_page, .instr_done, .irq_return, .rd_valid_reg, .rd_data_reg, .rd_bit_reg, .irq_taken_reg,
      .stack_pointer_reg, .stack_record_reg, .program_status_word_reg, .interrupt_enable_reg,
      .port_latch_reg, .active_page_reg, .paged_req_reg, .paged_we_reg, .paged_addr_reg,
      .paged_page_reg, .paged_wdata_reg);

   // clock and a hang limit far above the expected run
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         print_verdict();
      end
   end

   // registers held locally; anything else above 0x7F reads as zero
   function automatic logic known(input logic [7:0] a);
      return a inside {8'h80, 8'h81, 8'h84, 8'h85, 8'h86, 8'h8F, 8'h90, 8'hA0, 8'hA8, 8'hB0, 8'hD0};
   endfunction : known
   task automatic fail(input logic [31:0] g, e);
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
   endtask : fail
   task automatic chk1(input logic g, e);
      check_count++;
      if (g !== e) fail(g, e);
   endtask : chk1
   task automatic chk8(input logic [7:0] g, e);
      check_count++;
      if (g !== e) fail(g, e);
   endtask : chk8
   task automatic chk32(input logic [31:0] g, e);
      check_count++;
      if (g !== e) fail(g, e);
   endtask : chk32
   // one access, held for exactly one taken edge
   task automatic acc(input logic w, ix, bt, p, input logic [7:0] a, v, input logic wb);
      @(negedge mclk);
      {acc_valid, acc_write, acc_indirect, acc_bit, acc_ptr_sel, acc_wbit} = {1'h1, w, ix, bt, p, wb};
      {acc_addr, acc_wdata} = {a, v};
      @(negedge mclk);
      acc_valid = 1'h0;
      if (!w) chk1(rd_valid_reg, 1'h1);
   endtask : acc
   task automatic dir(input logic w, input logic [7:0] a, v);
      acc(w, 1'h0, 1'h0, 1'h0, a, v, 1'h0);
      if (w && a < 8'h80) mem[a] = v;
      else if (w && known(a)) special_function_register[a] = v;
      else if (!w) chk8(rd_data_reg, a < 8'h80 ? mem[a] : (known(a) ? special_function_register[a] : 8'h00));
   endtask : dir
   task automatic ind(input logic w, p, input logic [7:0] v);
      b = mem[{3'h0, bank, 2'h0, p}];
      acc(w, 1'h1, 1'h0, p, 8'h00, v, 1'h0);
      if (w) mem[b] = v;
      else chk8(rd_data_reg, mem[b]);
   endtask : ind
   task automatic stk(input logic pop, c, input logic [7:0] v);
      @(negedge mclk);
      {stk_pop, stk_push, stk_call, stk_wdata} = {pop, !pop, c, v};
      @(negedge mclk);
      {stk_pop, stk_push} = 2'h0;
      if (pop) chk8(rd_data_reg, mem[special_function_register[8'h81]]);
      if (pop) rec = rec >> 1;
      else rec = {rec[30:0], c};
      special_function_register[8'h81] = pop ? special_function_register[8'h81] - 8'h01 : special_function_register[8'h81] + 8'h01;
      if (!pop) mem[special_function_register[8'h81]] = v;
      chk8(stack_pointer_reg, special_function_register[8'h81]);
      chk32(stack_record_reg, rec);
   endtask : stk
   task automatic take(input logic [7:0] p);
      {irq_page, irq_pend} = {p, 1'h1};
      repeat (20) begin
         @(negedge mclk);
         if (irq_taken_reg === 1'h1) break;
      end
      irq_pend = 1'h0;
      chk1(irq_taken_reg, 1'h1);
      if (special_function_register[8'h8F][0]) {special_function_register[8'h86], special_function_register[8'h85], special_function_register[8'h84]} = {special_function_register[8'h85], special_function_register[8'h84], p};
      chk8(active_page_reg, special_function_register[8'h84]);
   endtask : take
   task automatic ret;
      repeat (100) begin
         @(negedge mclk);
         if (irq_return === 1'h1) break;
      end
      if (special_function_register[8'h8F][0]) {special_function_register[8'h84], special_function_register[8'h85]} = {special_function_register[8'h85], special_function_register[8'h86]};
      chk8(active_page_reg, special_function_register[8'h84]);
   endtask : ret
   task automatic print_verdict;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   // main sequence: reset, ram, bits, stack, pages, interrupts
   initial begin
      void'($urandom(32'hd22f4323));
      {irq_pend, acc_valid, acc_write, acc_indirect, acc_bit, acc_ptr_sel, acc_wbit} = '0;
      {stk_push, stk_pop, stk_call, acc_addr, acc_wdata, stk_wdata, irq_page, rec, bank} = '0;
      foreach (special_function_register[i]) special_function_register[i] = known(8'(i)) && i[3:0] == 4'h0 ? 8'hFF : 8'h00;
      {special_function_register[8'h81], special_function_register[8'h8F]} = {8'h07, 8'h01};
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      rst = 1'h0;
      chk8(stack_pointer_reg, 8'h07);
      chk32(stack_record_reg, 32'h0);
      chk32({program_status_word_reg, interrupt_enable_reg, active_page_reg}, 32'h0);
      chk32(port_latch_reg, 32'hFFFFFFFF);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         bank = 2'($urandom);
         dir(1'h1, 8'hD0, {3'h0, bank, 3'h0});
         dir(1'h1, 8'(8'h20 + i), 8'($urandom));
         dir(1'h0, 8'(8'h20 + i), 8'h00);
         dir(1'h1, {3'h0, bank, 2'h0, i[0]}, 8'($urandom_range(255, 32)));
         ind(1'h1, i[0], 8'($urandom));
         ind(1'h0, i[0], 8'h00);
      end
      dir(1'h1, {3'h0, bank, 3'h0}, 8'h81);
      ind(1'h1, 1'h0, 8'hAA);
      dir(1'h0, 8'h81, 8'h00);
      ind(1'h0, 1'h0, 8'h00);
      $display("test ram done");
      for (int i = 0; i < 12; i++) begin
         {b, d} = {8'($urandom_range(127, 0)), 8'($urandom)};
         acc(1'h1, 1'h0, 1'h1, 1'h0, b, 8'h00, d[0]);
         mem[8'h20 + b[6:3]][b[2:0]] = d[0];
         acc(1'h0, 1'h0, 1'h1, 1'h0, b, 8'h00, 1'h0);
         chk1(rd_bit_reg, d[0]);
         dir(1'h0, 8'h20 + b[6:3], 8'h00);
      end
      $display("test bits done");
      for (int i = 0; i < 4; i++) stk(1'h0, 1'h0, 8'($urandom));
      stk(1'h0, 1'h1, 8'($urandom));
      stk(1'h0, 1'h1, 8'($urandom));
      for (int i = 0; i < 6; i++) stk(1'h1, 1'h0, 8'h00);
      dir(1'h1, 8'h81, 8'hFE);
      stk(1'h0, 1'h0, 8'h5A);
      stk(1'h0, 1'h0, 8'hA5);
      stk(1'h1, 1'h0, 8'h00);
      stk(1'h1, 1'h0, 8'h00);
      $display("test stack done");
      for (int i = 4; i < 7; i++) dir(1'h1, 8'(8'h80 + i), 8'($urandom));
      for (int i = 4; i < 7; i++) dir(1'h0, 8'(8'h80 + i), 8'h00);
      dir(1'h0, 8'h8F, 8'h00);
      d = 8'($urandom);
      dir(1'h1, 8'hC3, d);
      chk1(paged_req_reg & paged_we_reg, 1'h1);
      chk32({paged_addr_reg, paged_page_reg, paged_wdata_reg}, {8'hC3, special_function_register[8'h84], d});
      for (int i = 0; i < 4; i++) begin
         dir(1'h1, 8'(8'h80 + 16 * i), 8'($urandom));
         chk1(paged_req_reg, 1'h0);
         dir(1'h0, 8'(8'h80 + 16 * i), 8'h00);
         chk1(paged_req_reg, 1'h0);
      end
      chk32(port_latch_reg, {special_function_register[8'hB0], special_function_register[8'hA0], special_function_register[8'h90], special_function_register[8'h80]});
      acc(1'h1, 1'h0, 1'h1, 1'h0, 8'h93, 8'h00, 1'h0);
      special_function_register[8'h90][3] = 1'h0;
      dir(1'h0, 8'h90, 8'h00);
      $display("test pages done");
      {irq_page, irq_pend} = {8'h3C, 1'h1};
      repeat (12) begin
         @(negedge mclk);
         chk1(irq_taken_reg, 1'h0);
      end
      irq_pend = 1'h0;
      dir(1'h1, 8'hA8, 8'h80);
      take(8'($urandom));
      take(8'($urandom));
      for (int i = 4; i < 7; i++) dir(1'h0, 8'(8'h80 + i), 8'h00);
      ret();
      ret();
      for (int i = 4; i < 6; i++) dir(1'h0, 8'(8'h80 + i), 8'h00);
      dir(1'h1, 8'h8F, 8'h00);
      take(8'h77);
      ret();
      $display("test interrupts done");
      print_verdict();
   end
endmodule : dms_data_mem_tb

// File: src/dms_data_mem.sv
// internal data memory addressing, stack pointer, stack record, core registers
// assumes the core issues at most one access or stack operation per cycle;
// all inputs come from core logic on mclk, so none is synchronised
`timescale 1ns/1ps

// Summary of operation
// RULE_01 - 256 bytes of internal RAM at data addresses 0x00 to 0xFF.
// RULE_02 - lower 128 bytes reachable by direct and by indirect addressing.
// RULE_03 - above 0x7F, direct goes to register space, indirect to upper RAM.
// RULE_04 - bytes 0x00-0x1F are four banks of eight, picked by status bits 3,4.
// RULE_05 - indirect pointer comes from register zero or one of active bank.
// RULE_06 - bytes 0x20-0x2F double as bits 0x00-0x7F, bit 8k+n.
// RULE_07 - bit versus byte access chosen by operand type, not address.
// RULE_08 - stack pointer at 0x81 holds last used slot; push writes pointer+1.
// RULE_09 - reset loads stack pointer with 0x07, first push lands at 0x08.
// RULE_10 - stack may sit anywhere and grow across all 256 bytes.
// RULE_11 - 32-bit record: push/increment adds one bit, pop/decrement removes one.
// RULE_12 - page control auto-switch enable comes out of reset set.
// RULE_13 - port latches and core registers are reachable from every page.
// RULE_14 - on interrupt entry with auto-switch, load page of interrupting source.
// RULE_15 - entry pushes old active to saved and old saved to bottom.
// RULE_16 - interrupts taken after instruction completes and only with global enable.
// RULE_17 - return with auto-switch pops: saved to active, bottom to saved.
// RULE_18 - software writes to the three page registers store directly.
module dms_data_mem
   import dms_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        acc_valid,
   input  wire logic        acc_write,
   input  wire logic        acc_indirect,
   input  wire logic        acc_bit,
   input  wire logic        acc_ptr_sel,
   input  wire logic [7:0]  acc_addr,
   input  wire logic [7:0]  acc_wdata,
   input  wire logic        acc_wbit,
   input  wire logic        stk_push,
   input  wire logic        stk_pop,
   input  wire logic        stk_call,
   input  wire logic [7:0]  stk_wdata,
   input  wire logic        irq_req,
   input  wire logic [7:0]  irq_page,
   input  wire logic        instr_done,
   input  wire logic        irq_return,
   output logic             rd_valid_reg,
   output logic      [7:0]  rd_data_reg,
   output logic             rd_bit_reg,
   output logic             irq_taken_reg,
   output logic      [7:0]  stack_pointer_reg,
   output logic      [DMS_REC_W-1:0] stack_record_reg,
   output logic      [7:0]  program_status_word_reg,
   output logic      [7:0]  interrupt_enable_reg,
   output logic      [31:0] port_latch_reg,
   output logic      [7:0]  active_page_reg,
   output logic             paged_req_reg,
   output logic             paged_we_reg,
   output logic      [7:0]  paged_addr_reg,
   output logic      [7:0]  paged_page_reg,
   output logic      [7:0]  paged_wdata_reg
);
   logic [7:0] saved_page_reg;
   logic [7:0] bottom_page_reg;
   logic       auto_en_reg;
   logic [7:0] ptr_addr;
   logic [7:0] ptr_val;
   logic [7:0] bit_byte_addr;
   logic [7:0] eff_addr;
   logic       is_sfr;
   logic       access_go;
   logic [7:0] ram_raddr;
   logic [7:0] ram_rdata;
   logic       ram_we;
   logic [7:0] ram_waddr;
   logic [7:0] ram_wdata;
   logic [7:0] sfr_rdata;
   logic       own_hit;
   logic       port_hit;
   logic [7:0] port_rdata;
   logic [7:0] byte_old;
   logic [7:0] bit_mask;
   logic [7:0] byte_new;
   logic       sfr_we;
   logic       sp_sw_we;
   logic [7:0] sp_inc;
   logic [7:0] sp_dec;
   logic [7:0] sp_next;
   logic       rec_in;
   logic       rec_out;
   logic       irq_take;
   logic [DMS_NUM_PORTS-1:0] port_sel;
   logic [31:0]              port_next;

   // pointer fetch from active bank, then effective address
   assign ptr_addr      = {3'h0, program_status_word_reg[DMS_PSW_BANK_HI:DMS_PSW_BANK_LO],
                           2'h0, acc_ptr_sel};             // see RULE_04 see RULE_05
   assign bit_byte_addr = acc_addr[7] ? {acc_addr[7:3], 3'h0}
                                      : {DMS_BIT_BYTE_HI, acc_addr[6:3]}; // see RULE_06
   assign eff_addr      = acc_bit      ? bit_byte_addr :   // see RULE_07
                          acc_indirect ? ptr_val : acc_addr; // see RULE_02
   // only direct accesses above 0x7F reach register space
   assign is_sfr        = ~acc_indirect & eff_addr[7];     // see RULE_03
   // a stack operation owns the cycle; a same-cycle access is dropped
   assign access_go     = acc_valid & ~stk_push & ~stk_pop;

   // stack pointer arithmetic wraps over the full 256 bytes
   assign sp_inc        = stack_pointer_reg + 8'h01;       // see RULE_10
   assign sp_dec        = stack_pointer_reg - 8'h01;

   // shared RAM data port serves pops and ordinary accesses
   assign ram_raddr     = stk_pop ? stack_pointer_reg : eff_addr;
   assign ram_we        = stk_push | (access_go & acc_write & ~is_sfr); // see RULE_01
   assign ram_waddr     = stk_push ? sp_inc : eff_addr;    // see RULE_08
   assign ram_wdata     = stk_push ? stk_wdata : byte_new;

   dms_ram u_ram (
      .mclk      (mclk),
      .we        (ram_we),
      .waddr     (ram_waddr),
      .wdata     (ram_wdata),
      .raddr_ptr (ptr_addr),
      .rdata_ptr (ptr_val),
      .raddr_dat (ram_raddr),
      .rdata_dat (ram_rdata)
   );

   // port latches decode the same on every page
   genvar gi;
   generate
      for (gi = 0; gi < DMS_NUM_PORTS; gi++) begin : g_port
         assign port_sel[gi] = eff_addr == 8'(DMS_PORT_BASE + gi * DMS_PORT_STEP); // see RULE_13
         assign port_next[gi*8 +: 8] = (sfr_we && port_sel[gi]) ? byte_new : port_latch_reg[gi*8 +: 8];
      end
   endgenerate

   // one process for all latches keeps a single driver on the vector
   always_ff @(posedge mclk) begin
      if (rst) begin
         port_latch_reg <= {DMS_NUM_PORTS{DMS_PORT_RST}};
      end else begin
         port_latch_reg <= port_next;
      end
   end

   // own registers answer regardless of the active page
   assign port_hit   = |port_sel;
   assign port_rdata = port_latch_reg[{eff_addr[5:4], 3'h0} +: 8];
   assign own_hit    = port_hit || eff_addr == DMS_SP_ADDR || eff_addr == DMS_PSW_ADDR
                    || eff_addr == DMS_IE_ADDR || eff_addr == DMS_PAGE_ADDR
                    || eff_addr == DMS_NEXT_ADDR || eff_addr == DMS_LAST_ADDR
                    || eff_addr == DMS_PGCN_ADDR;           // see RULE_13
   assign sfr_rdata  = port_hit                   ? port_rdata :
                       eff_addr == DMS_SP_ADDR    ? stack_pointer_reg :
                       eff_addr == DMS_PSW_ADDR   ? program_status_word_reg :
                       eff_addr == DMS_IE_ADDR    ? interrupt_enable_reg :
                       eff_addr == DMS_PAGE_ADDR  ? active_page_reg :
                       eff_addr == DMS_NEXT_ADDR  ? saved_page_reg :
                       eff_addr == DMS_LAST_ADDR  ? bottom_page_reg :
                       eff_addr == DMS_PGCN_ADDR  ? {7'h00, auto_en_reg} : 8'h00;

   // bit writes are read-modify-write of the holding byte
   assign byte_old = is_sfr ? sfr_rdata : ram_rdata;
   assign bit_mask = 8'h01 << acc_addr[2:0];
   assign byte_new = acc_bit ? ((byte_old & ~bit_mask) | ({8{acc_wbit}} & bit_mask))
                             : acc_wdata;                   // see RULE_07
   assign sfr_we   = access_go & acc_write & is_sfr;
   assign sp_sw_we = sfr_we & (eff_addr == DMS_SP_ADDR);

   // software writes of pointer +/-1 count as increment or decrement
   assign rec_in  = stk_push | (sp_sw_we & (byte_new == sp_inc));  // see RULE_11
   assign rec_out = stk_pop  | (sp_sw_we & (byte_new == sp_dec));  // see RULE_11
   assign sp_next = stk_push ? sp_inc :                    // see RULE_08
                    stk_pop  ? sp_dec :
                    sp_sw_we ? byte_new : stack_pointer_reg;

   // taken only at an instruction boundary with the global enable set
   assign irq_take = irq_req & instr_done & interrupt_enable_reg[DMS_IE_GLOBAL]; // see RULE_16

   dms_page_stack u_pages (
      .mclk            (mclk),
      .rst             (rst),
      .irq_push        (irq_take),
      .irq_ret         (irq_return),
      .vec_page        (irq_page),
      .wr_active       (sfr_we & (eff_addr == DMS_PAGE_ADDR)),
      .wr_saved        (sfr_we & (eff_addr == DMS_NEXT_ADDR)),
      .wr_bottom       (sfr_we & (eff_addr == DMS_LAST_ADDR)),
      .wr_ctrl         (sfr_we & (eff_addr == DMS_PGCN_ADDR)),
      .wr_data         (byte_new),
      .active_page_reg (active_page_reg),
      .saved_page_reg  (saved_page_reg),
      .bottom_page_reg (bottom_page_reg),
      .auto_en_reg     (auto_en_reg)
   );

   // stack pointer and record
   always_ff @(posedge mclk) begin
      if (rst) begin
         stack_pointer_reg <= DMS_SP_RST;                   // see RULE_09
         stack_record_reg  <= '0;
      end else begin
         stack_pointer_reg <= sp_next;
         if (rec_in) begin
            stack_record_reg <= {stack_record_reg[DMS_REC_W-2:0], stk_push & stk_call};
         end else if (rec_out) begin
            stack_record_reg <= {1'b0, stack_record_reg[DMS_REC_W-1:1]};
         end
      end
   end

   // status word and interrupt enable
   always_ff @(posedge mclk) begin
      if (rst) begin
         program_status_word_reg <= DMS_PSW_RST;
         interrupt_enable_reg    <= DMS_IE_RST;
      end else begin
         if (sfr_we && eff_addr == DMS_PSW_ADDR) program_status_word_reg <= byte_new;
         if (sfr_we && eff_addr == DMS_IE_ADDR)  interrupt_enable_reg    <= byte_new;
      end
   end

   // read answers one cycle after the request
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_valid_reg  <= 1'b0;
         rd_data_reg   <= 8'h00;
         rd_bit_reg    <= 1'b0;
         irq_taken_reg <= 1'b0;
      end else begin
         rd_valid_reg  <= stk_pop | (access_go & ~acc_write);
         rd_data_reg   <= stk_pop ? ram_rdata : byte_old;
         rd_bit_reg    <= byte_old[acc_addr[2:0]];
         irq_taken_reg <= irq_take;
      end
   end

   // other registers are handed to the peripheral side with the active page
   always_ff @(posedge mclk) begin
      if (rst) begin
         paged_req_reg   <= 1'b0;
         paged_we_reg    <= 1'b0;
         paged_addr_reg  <= 8'h00;
         paged_page_reg  <= 8'h00;
         paged_wdata_reg <= 8'h00;
      end else begin
         paged_req_reg   <= access_go & is_sfr & ~own_hit;
         paged_we_reg    <= access_go & is_sfr & ~own_hit & acc_write;
         paged_addr_reg  <= eff_addr;
         paged_page_reg  <= active_page_reg;
         paged_wdata_reg <= byte_new;
      end
   end

   sp_reset_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_09
      $fell(rst) |-> stack_pointer_reg == 8'h07)
      else $error("stack pointer not 0x07 after reset");
   push_sp_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_08
      stk_push |=> stack_pointer_reg == 8'($past(stack_pointer_reg) + 8'h01))
      else $error("push did not increment stack pointer");
   push_record_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_11
      stk_push |=> stack_record_reg == {$past(stack_record_reg[30:0]), $past(stk_call)})
      else $error("push did not shift stack record");
   pop_record_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_11
      stk_pop && !stk_push |=> stack_record_reg == {1'b0, $past(stack_record_reg[31:1])}
         && stack_pointer_reg == 8'($past(stack_pointer_reg) - 8'h01))
      else $error("pop did not shift record or decrement pointer");
   bank_ptr_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_05
      acc_valid && acc_indirect && !acc_bit |-> ptr_addr[4:3] == program_status_word_reg[4:3]
         && ptr_addr[7:5] == 3'h0 && ptr_addr[2:1] == 2'h0)
      else $error("pointer not taken from active bank");
   upper_route_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_03
      access_go && acc_indirect && !acc_bit && acc_write |=> !paged_req_reg
         && $stable(stack_pointer_reg) && $stable(port_latch_reg))
      else $error("indirect access reached register space");
   bit_map_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_06
      acc_valid && acc_bit && !acc_addr[7] |-> eff_addr == 8'h20 + {4'h0, acc_addr[6:3]})
      else $error("bit address mapped to wrong byte");
   irq_gate_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_16
      irq_taken_reg |-> $past(interrupt_enable_reg[7]) && $past(instr_done) && $past(irq_req))
      else $error("interrupt taken without global enable or boundary");
   paged_read_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_13
      access_go && !acc_write && port_hit && !acc_bit |=> rd_valid_reg && !paged_req_reg)
      else $error("port latch read went to paged space");
endmodule : dms_data_mem

// File: src/dms_page_stack.sv
// three-level register page stack with automatic switching on interrupts
// assumes push and pop are single-cycle pulses from the interrupt logic
`timescale 1ns/1ps
module dms_page_stack
   import dms_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       irq_push,
   input  wire logic       irq_ret,
   input  wire logic [7:0] vec_page,
   input  wire logic       wr_active,
   input  wire logic       wr_saved,
   input  wire logic       wr_bottom,
   input  wire logic       wr_ctrl,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] active_page_reg,
   output logic      [7:0] saved_page_reg,
   output logic      [7:0] bottom_page_reg,
   output logic            auto_en_reg
);
   logic do_push;
   logic do_pop;

   // hardware moves only while automatic switching is on
   assign do_push = irq_push & auto_en_reg;                 // see RULE_14
   assign do_pop  = irq_ret & auto_en_reg & ~irq_push;      // see RULE_17

   // hardware moves win over a software write in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         active_page_reg <= DMS_PAGE_RST;
         saved_page_reg  <= DMS_PAGE_RST;
         bottom_page_reg <= DMS_PAGE_RST;
      end else if (do_push) begin
         active_page_reg <= vec_page;                       // see RULE_14
         saved_page_reg  <= active_page_reg;                // see RULE_15
         bottom_page_reg <= saved_page_reg;                 // see RULE_15
      end else if (do_pop) begin
         active_page_reg <= saved_page_reg;                 // see RULE_17
         saved_page_reg  <= bottom_page_reg;                // see RULE_17
      end else begin
         if (wr_active) active_page_reg <= wr_data;         // see RULE_18
         if (wr_saved)  saved_page_reg  <= wr_data;         // see RULE_18
         if (wr_bottom) bottom_page_reg <= wr_data;         // see RULE_18
      end
   end

   // enable comes out of reset set
   always_ff @(posedge mclk) begin
      if (rst) begin
         auto_en_reg <= DMS_AUTO_RST;                       // see RULE_12
      end else if (wr_ctrl) begin
         auto_en_reg <= wr_data[DMS_PGCN_AUTO];
      end
   end

   push_shift_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_15
      do_push |=> active_page_reg == $past(vec_page) && saved_page_reg == $past(active_page_reg)
                  && bottom_page_reg == $past(saved_page_reg))
      else $error("page stack push did not shift");
   pop_shift_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_17
      do_pop |=> active_page_reg == $past(saved_page_reg) && saved_page_reg == $past(bottom_page_reg))
      else $error("page stack pop did not shift");
   auto_reset_a: assert property (@(posedge mclk) disable iff (rst) // see RULE_12
      $fell(rst) |-> auto_en_reg)
      else $error("auto page switch not enabled after reset");
endmodule : dms_page_stack

// File: src/dms_pkg.sv
// constants for the internal data memory, stack and register page block
// assumes one system clock and a synchronous active-high core reset
package dms_pkg;
   // special function register addresses
   localparam logic [7:0] DMS_SP_ADDR     = 8'h81;
   localparam logic [7:0] DMS_PAGE_ADDR   = 8'h84;
   localparam logic [7:0] DMS_NEXT_ADDR   = 8'h85;
   localparam logic [7:0] DMS_LAST_ADDR   = 8'h86;
   localparam logic [7:0] DMS_PGCN_ADDR   = 8'h8F;
   localparam logic [7:0] DMS_IE_ADDR     = 8'hA8;
   localparam logic [7:0] DMS_PSW_ADDR    = 8'hD0;
   localparam logic [7:0] DMS_PORT_BASE   = 8'h80;
   localparam logic [7:0] DMS_PORT_STEP   = 8'h10;
   localparam int         DMS_NUM_PORTS   = 4;
   // reset values
   localparam logic [7:0] DMS_SP_RST      = 8'h07;
   localparam logic [7:0] DMS_PSW_RST     = 8'h00;
   localparam logic [7:0] DMS_IE_RST      = 8'h00;
   localparam logic [7:0] DMS_PAGE_RST    = 8'h00;
   localparam logic [7:0] DMS_PORT_RST    = 8'hFF;
   localparam logic       DMS_AUTO_RST    = 1'b1;
   // field positions
   localparam int         DMS_PSW_BANK_LO = 3;
   localparam int         DMS_PSW_BANK_HI = 4;
   localparam int         DMS_IE_GLOBAL   = 7;
   localparam int         DMS_PGCN_AUTO   = 0;
   // memory map
   localparam logic [3:0] DMS_BIT_BYTE_HI = 4'h2;
   localparam int         DMS_RAM_DEPTH   = 256;
   localparam int         DMS_REC_W       = 32;
endpackage : dms_pkg

// File: src/dms_ram.sv
// 256-byte internal data RAM, two combinational read ports, one write port
// assumes the caller resolves addressing mode; contents survive reset
`timescale 1ns/1ps
module dms_ram
   import dms_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       we,
   input  wire logic [7:0] waddr,
   input  wire logic [7:0] wdata,
   input  wire logic [7:0] raddr_ptr,
   output logic      [7:0] rdata_ptr,
   input  wire logic [7:0] raddr_dat,
   output logic      [7:0] rdata_dat
);
   logic [7:0] mem [DMS_RAM_DEPTH];

   // no reset on purpose: stored data is preserved across reset
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // pointer port feeds the data port in the same cycle
   assign rdata_ptr = mem[raddr_ptr];
   assign rdata_dat = mem[raddr_dat];
endmodule : dms_ram
